// *** verilog/dccr_top.sv ***
// DMA channel 0 register block: control, address and count registers with
// the sub-channel B transfer sequencer and a transfer queue.
// Assumes an APB master on pclk and a transfer engine draining xfer_*.
// Operation
// R1 - Transfers only while enable bit set
// R2 - Direction 0 raises address by 1/2
// R3 - Direction 1 lowers address by 1/2
// R4 - Interrupt enable gates completion request
// R5 - Request raised once enable bit clears
// R6 - Repeat and interrupt bits select mode
// R7 - Codes 0-5 pick timer or serial source
// R8 - Channel A codes 110/111 select full mode
// R9 - Channel B: request pin edge or level
// R10 - Full mode source fixed or increments
// R11 - Full mode source decrements when enabled
// R12 - Address upper byte reads ones, read-only
// R13 - Repeat: upper byte counts, lower reloads
// R14 - I/O address used only in short mode
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module dccr_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_reg != D[AW:0]);
    assign out_valid = (cnt_reg != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rp_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dccr_fifo

module dccr_top
    import dccr_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Activation sources
    input  wire logic [3:0]        timer_match_a,
    input  wire logic              serial_channel_zero_tx_empty,
    input  wire logic              serial_channel_zero_rx_full,
    input  wire logic              external_transfer_request_n,
    // Transfer queue out
    output logic                   xfer_valid,
    input  wire logic              xfer_ready,
    output dccr_xfer_t             xfer_data,
    // Completion requests
    output logic                   irq_a,
    output logic                   irq_b
);
    dccr_ctrl_t  ctrl_a_reg;
    dccr_ctrl_t  ctrl_b_reg;
    logic [23:0] mar_reg;
    logic [23:0] base_reg;
    logic [23:0] src_reg;
    logic [15:0] cnt_reg;
    logic [7:0]  io_reg;
    logic [31:0] prdata_reg;
    logic        s1_reg;
    logic        s2_reg;
    logic        s3_reg;
    logic        lvl_reg;

    logic        wr;
    logic        hit;
    logic        full_mode;
    dccr_mode_t  mode;
    logic        trig;
    logic        chan_ok;
    logic        fire;
    logic        q_ready;
    logic        size;
    logic [23:0] step;
    logic        rpt;
    logic        last;
    logic        ext_fall;
    dccr_xfer_t  q_data;

    // Zero-wait slave; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign wr      = psel & penable & pwrite;
    assign hit     = (paddr == ADR_A_SRC) | (paddr == ADR_A_CTRL) |
                     (paddr == ADR_B_MAR) | (paddr == ADR_B_CNT) |
                     (paddr == ADR_B_IO) | (paddr == ADR_B_CTRL);
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (psel & ~penable) begin
            case (paddr)
                ADR_A_SRC:  prdata_reg <= {MAR_HI, src_reg};
                ADR_A_CTRL: prdata_reg <= {24'h000000, ctrl_a_reg};
                ADR_B_MAR:  prdata_reg <= {MAR_HI, mar_reg}; // see R12
                ADR_B_CNT:  prdata_reg <= {16'h0000, cnt_reg};
                ADR_B_IO:   prdata_reg <= {24'h000000, io_reg};
                ADR_B_CTRL: prdata_reg <= {24'h000000, ctrl_b_reg};
                default:    prdata_reg <= '0;
            endcase
        end
    end

    // Request pin: three stages, a change counts once stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg  <= 1'b1;
            s2_reg  <= 1'b1;
            s3_reg  <= 1'b1;
            lvl_reg <= 1'b1;
        end else begin
            s1_reg <= external_transfer_request_n;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s2_reg;
            end
        end
    end
    assign ext_fall = lvl_reg & ~s2_reg & ~s3_reg;

    assign full_mode = (ctrl_a_reg.sel[2:1] == SEL_FULL); // see R8

    always_comb begin
        case ({ctrl_b_reg.repeat_select_bit, ctrl_b_reg.ie}) // see R6
            2'b10:   mode = MODE_REPEAT;
            2'b11:   mode = MODE_IDLE;
            default: mode = MODE_IO;
        endcase
    end

    always_comb begin
        case (ctrl_b_reg.sel) // see R7
            SEL_SCI_TX: trig = serial_channel_zero_tx_empty;
            SEL_SCI_RX: trig = serial_channel_zero_rx_full;
            SEL_EDGE:   trig = ext_fall; // see R9
            SEL_LEVEL:  trig = ~lvl_reg; // see R9
            default:    trig = timer_match_a[ctrl_b_reg.sel[1:0]];
        endcase
    end

    // Full mode needs channel A's enable as well
    assign chan_ok = ctrl_b_reg.en & (~full_mode | ctrl_a_reg.en); // see R1
    // Queue back-pressure stalls the sequencer; level requests simply wait
    assign fire    = chan_ok & trig & q_ready;
    assign size    = full_mode ? ctrl_a_reg.size : ctrl_b_reg.size;
    assign step    = size ? STEP_WORD : STEP_BYTE;
    assign rpt     = ~full_mode & (mode == MODE_REPEAT);
    assign last    = rpt ? (cnt_reg[15:8] == RPT_LAST) : (cnt_reg == CNT_LAST);

    always_comb begin
        q_data.mem  = mar_reg;
        q_data.src  = full_mode ? src_reg : ADDR_RST;
        q_data.io   = full_mode ? IO_RST : io_reg; // see R14
        q_data.size = size;
        q_data.full = full_mode;
    end

    // Memory address; a software write also sets the repeat reload point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mar_reg  <= ADDR_RST;
            base_reg <= ADDR_RST;
        end else if (wr & (paddr == ADR_B_MAR)) begin
            mar_reg  <= pwdata[23:0]; // see R12
            base_reg <= pwdata[23:0];
        end else if (fire) begin
            if (rpt & last) begin
                mar_reg <= base_reg; // see R13
            end else if (full_mode | (mode != MODE_IDLE)) begin
                mar_reg <= ctrl_b_reg.dir ? mar_reg - step : mar_reg + step; // see R2 R3
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_reg <= ADDR_RST;
        end else if (wr & (paddr == ADR_A_SRC)) begin
            src_reg <= pwdata[23:0];
        end else if (fire & full_mode & ctrl_a_reg.repeat_select_bit) begin
            src_reg <= ctrl_a_reg.dir ? src_reg - step : src_reg + step; // see R10 R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= CNT_RST;
        end else if (wr & (paddr == ADR_B_CNT)) begin
            cnt_reg <= pwdata[15:0];
        end else if (fire) begin
            if (rpt) begin
                cnt_reg[15:8] <= last ? cnt_reg[7:0] : cnt_reg[15:8] - 8'h01; // see R13
            end else begin
                cnt_reg <= cnt_reg - CNT_LAST;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_reg <= IO_RST;
        end else if (wr & (paddr == ADR_B_IO)) begin
            io_reg <= pwdata[7:0];
        end
    end

    // Software write wins over the end-of-count clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_b_reg <= CTRL_RST;
        end else if (wr & (paddr == ADR_B_CTRL)) begin
            ctrl_b_reg <= pwdata[7:0];
        end else if (fire & ~rpt & last) begin
            ctrl_b_reg.en <= 1'b0; // see R1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_reg <= CTRL_RST;
        end else if (wr & (paddr == ADR_A_CTRL)) begin
            ctrl_a_reg <= pwdata[7:0];
        end else if (fire & full_mode & last) begin
            ctrl_a_reg.en <= 1'b0;
        end
    end

    assign irq_a = ctrl_a_reg.ie & ~ctrl_a_reg.en; // see R4 R5
    assign irq_b = ctrl_b_reg.ie & ~ctrl_b_reg.en; // see R4 R5

    dccr_fifo #(
        .W ($bits(dccr_xfer_t)),
        .D (FIFO_DEPTH)
    ) u_queue (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (fire),
        .in_ready  (q_ready),
        .in_data   (q_data),
        .out_valid (xfer_valid),
        .out_ready (xfer_ready),
        .out_data  (xfer_data)
    );

    logic nowr;
    assign nowr = ~wr;

    AST_NO_FIRE_DISABLED: assert property (@(posedge pclk) disable iff (!presetn) // see R1
        !ctrl_b_reg.en & nowr |=> $stable(mar_reg) && $stable(cnt_reg))
        else $error("transfer while disabled");
    AST_INC: assert property (@(posedge pclk) disable iff (!presetn) // see R2
        fire & nowr & ~ctrl_b_reg.dir & ~rpt & (mode != MODE_IDLE)
        |=> mar_reg == $past(mar_reg) + (($past(size)) ? 24'h000002 : 24'h000001))
        else $error("address increment wrong");
    AST_DEC: assert property (@(posedge pclk) disable iff (!presetn) // see R3
        fire & nowr & ctrl_b_reg.dir & ~rpt & (mode != MODE_IDLE)
        |=> mar_reg == $past(mar_reg) - (($past(size)) ? 24'h000002 : 24'h000001))
        else $error("address decrement wrong");
    AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see R4
        !ctrl_b_reg.ie |-> !irq_b) else $error("request not gated");
    AST_IRQ_DONE: assert property (@(posedge pclk) disable iff (!presetn) // see R5
        fire & nowr & ~rpt & last & ctrl_b_reg.ie ##1 nowr |=> irq_b)
        else $error("no request after end of count");
    AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // see R6
        fire & nowr & ~full_mode & (mode == MODE_IDLE) |=> $stable(mar_reg))
        else $error("idle mode moved address");
    AST_SCI_TX: assert property (@(posedge pclk) disable iff (!presetn) // see R7
        chan_ok & q_ready & (ctrl_b_reg.sel == 3'h4) & serial_channel_zero_tx_empty |-> fire)
        else $error("serial source ignored");
    AST_FULL_TAG: assert property (@(posedge pclk) disable iff (!presetn) // see R8
        fire & (ctrl_a_reg.sel[2:1] == 2'b11) |-> q_data.full && ctrl_a_reg.en)
        else $error("full mode not taken");
    AST_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // see R9
        chan_ok & q_ready & (ctrl_b_reg.sel == 3'h7) & !s2_reg & !s3_reg ##1
        chan_ok & q_ready & (ctrl_b_reg.sel == 3'h7) |-> fire)
        else $error("low level request ignored");
    AST_SRC_FIXED: assert property (@(posedge pclk) disable iff (!presetn) // see R10
        fire & nowr & full_mode & ~ctrl_a_reg.repeat_select_bit |=> $stable(src_reg))
        else $error("source moved while fixed");
    AST_SRC_DEC: assert property (@(posedge pclk) disable iff (!presetn) // see R11
        fire & nowr & full_mode & ctrl_a_reg.repeat_select_bit & ctrl_a_reg.dir
        |=> src_reg == $past(src_reg) - (($past(size)) ? 24'h000002 : 24'h000001))
        else $error("source decrement wrong");
    AST_MAR_TOP: assert property (@(posedge pclk) disable iff (!presetn) // see R12
        psel & penable & !pwrite & $past(psel & ~penable) & (paddr == ADR_B_MAR)
        |-> prdata[31:24] == 8'hFF) else $error("upper address byte not ones");
    AST_RPT_RELOAD: assert property (@(posedge pclk) disable iff (!presetn) // see R13
        fire & nowr & rpt & (cnt_reg[15:8] == 8'h01)
        |=> (cnt_reg[15:8] == $past(cnt_reg[7:0])) && (mar_reg == $past(base_reg)))
        else $error("repeat reload wrong");
    AST_IO_USE: assert property (@(posedge pclk) disable iff (!presetn) // see R14
        xfer_valid & xfer_ready & xfer_data.full |-> xfer_data.io == 8'h00)
        else $error("io address misuse");

endmodule : dccr_top
`default_nettype wire

// *** verilog/dccr_pkg.sv ***
// Package for the DMA channel 0 control and address register block.
// Assumes APB with 32-bit data; registers sit at four times their index.
package dccr_pkg;

    localparam int unsigned ADDR_W = 12;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_A_SRC  = 8'h20;
    localparam logic [7:0] IDX_A_CTRL = 8'h27;
    localparam logic [7:0] IDX_B_MAR  = 8'h28;
    localparam logic [7:0] IDX_B_CNT  = 8'h2C;
    localparam logic [7:0] IDX_B_IO   = 8'h2E;
    localparam logic [7:0] IDX_B_CTRL = 8'h2F;

    localparam logic [ADDR_W-1:0] ADR_A_SRC  = {2'b00, IDX_A_SRC, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_A_CTRL = {2'b00, IDX_A_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_B_MAR  = {2'b00, IDX_B_MAR, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_B_CNT  = {2'b00, IDX_B_CNT, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_B_IO   = {2'b00, IDX_B_IO, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_B_CTRL = {2'b00, IDX_B_CTRL, 2'b00};

    // Reset and fixed values
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [7:0]  MAR_HI    = 8'hFF;
    localparam logic [23:0] ADDR_RST  = 24'h000000;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [7:0]  IO_RST    = 8'h00;

    // Address steps and count marks
    localparam logic [23:0] STEP_BYTE = 24'h000001;
    localparam logic [23:0] STEP_WORD = 24'h000002;
    localparam logic [15:0] CNT_LAST  = 16'h0001;
    localparam logic [7:0]  RPT_LAST  = 8'h01;

    // Activation select codes
    localparam logic [2:0] SEL_SCI_TX = 3'h4;
    localparam logic [2:0] SEL_SCI_RX = 3'h5;
    localparam logic [2:0] SEL_EDGE   = 3'h6;
    localparam logic [2:0] SEL_LEVEL  = 3'h7;
    localparam logic [1:0] SEL_FULL   = 2'h3;

    localparam int unsigned FIFO_DEPTH = 8;

    // Control byte; in full-address layout dir/rpe carry the source step bits
    typedef struct packed {
        logic       en;
        logic       size;
        logic       dir;
        logic       repeat_select_bit;
        logic       ie;
        logic [2:0] sel;
    } dccr_ctrl_t;

    // One queued transfer
    typedef struct packed {
        logic [23:0] mem;
        logic [23:0] src;
        logic [7:0]  io;
        logic        size;
        logic        full;
    } dccr_xfer_t;

    typedef enum logic [1:0] {
        MODE_IO,
        MODE_REPEAT,
        MODE_IDLE
    } dccr_mode_t;

endpackage : dccr_pkg

// *** sim/tb_dma_channel0_control_regs.sv ***
// Testbench for the DMA channel 0 register block.
// Drives APB, activation sources and the transfer queue directly, no model.
`timescale 1ns/1ps
`default_nettype none

module tb_dma_channel0_control_regs import dccr_pkg::*;;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [3:0]        timer_match_a;
    logic              serial_channel_zero_tx_empty;
    logic              serial_channel_zero_rx_full;
    logic              external_transfer_request_n;
    logic              xfer_valid;
    logic              xfer_ready;
    dccr_xfer_t        xfer_data;
    dccr_xfer_t        last;
    logic              irq_a;
    logic              irq_b;
    int                fails;
    int                checked;
    int                cyc;
    int                nxf;
    int                n0;
    logic [31:0]       d;
    logic [31:0]       e;
    logic [2:0]        c;
    logic [7:0]        ct;
    logic [7:0]        fa [4] = '{8'h86, 8'hD6, 8'hB7, 8'h07};
    logic [23:0]       fs [4] = '{24'h004000, 24'h004002, 24'h003FFF, 24'h004000};
    logic [23:0]       fm [4] = '{24'h005001, 24'h005002, 24'h005001, 24'h005000};

    dccr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_match_a(timer_match_a), .serial_channel_zero_tx_empty(serial_channel_zero_tx_empty),
        .serial_channel_zero_rx_full(serial_channel_zero_rx_full),
        .external_transfer_request_n(external_transfer_request_n),
        .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_data(xfer_data),
        .irq_a(irq_a), .irq_b(irq_b));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // Hang guard; the whole run needs about 600 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    always @(posedge pclk) begin
        if (xfer_valid === 1'b1 && xfer_ready === 1'b1) begin
            nxf++;
            last <= xfer_data;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request is held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic [31:0] er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = {31'h0, pslverr};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic [31:0] s;
        xfer(1'b1, a, wd, r, s);
        // Let the write settle before outputs that follow it are looked at
        @(posedge pclk);
    endtask : wr

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic [31:0] s;
        xfer(1'b0, a, 32'h0, r, s);
        chk(r, exp);
    endtask : rdc

    task automatic cfg(input logic [23:0] m, input logic [15:0] n, input logic [7:0] ctl);
        wr(ADR_B_MAR, {8'h00, m});
        wr(ADR_B_CNT, {16'h0, n});
        wr(ADR_B_CTRL, {24'h0, ctl});
    endtask : cfg

    // One-cycle pulse on timers 0..3, serial tx-empty, serial rx-full
    task automatic pulse(input logic [5:0] v);
        timer_match_a <= v[3:0];
        serial_channel_zero_tx_empty <= v[4];
        serial_channel_zero_rx_full  <= v[5];
        @(posedge pclk);
        timer_match_a <= 4'h0;
        serial_channel_zero_tx_empty <= 1'b0;
        serial_channel_zero_rx_full  <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    task automatic pin(input logic v, input int n);
        external_transfer_request_n <= v;
        repeat (n) @(posedge pclk);
    endtask : pin

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {timer_match_a, serial_channel_zero_tx_empty, serial_channel_zero_rx_full} = '0;
        external_transfer_request_n = 1'b1;
        xfer_ready = 1'b1;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADR_A_CTRL, 32'h0);
        rdc(ADR_B_CTRL, 32'h0);
        rdc(ADR_B_MAR, 32'hFF000000);
        xfer(1'b0, 12'h004, 32'h0, d, e);
        chk(e, 32'h1);
        chk(d, 32'h0);
        wr(ADR_B_MAR, 32'hAB123456);
        rdc(ADR_B_MAR, 32'hFF123456);
        wr(ADR_B_IO, 32'h5A);
        rdc(ADR_B_IO, 32'h5A);
        wr(ADR_B_CTRL, 32'h08);
        chk({31'h0, irq_b}, 32'h1);
        wr(ADR_B_CTRL, 32'h00);
        chk({31'h0, irq_b}, 32'h0);
        wr(ADR_A_CTRL, 32'h08);
        chk({31'h0, irq_a}, 32'h1);
        wr(ADR_A_CTRL, 32'h00);
        cfg(24'h001000, 16'h1, 8'h00);
        pulse(6'h3F);
        rdc(ADR_B_MAR, 32'hFF001000);
        // Each timer and serial source code (0-5), with size and direction varied across codes
        for (int i = 0; i < 6; i++) begin
            c  = i[2:0];
            ct = {1'b1, c[0], c[1], 1'b0, 1'b1, c};
            cfg(24'h001000, 16'h1, ct);
            chk({31'h0, irq_b}, 32'h0);
            pulse(~(6'h01 << i));
            rdc(ADR_B_MAR, 32'hFF001000);
            pulse(6'h01 << i);
            rdc(ADR_B_MAR, c[1] ? 32'hFF001000 - (c[0] ? 2 : 1)
                                : 32'hFF001000 + (c[0] ? 2 : 1));
            rdc(ADR_B_CTRL, {24'h0, ct & 8'h7F});
            chk({31'h0, irq_b}, 32'h1);
            chk({24'h0, last.io}, 32'h5A);
            chk({8'h0, last.mem}, 32'h001000);
        end
        cfg(24'h003000, 16'h10, 8'h86);
        pin(1'b0, 20);
        rdc(ADR_B_MAR, 32'hFF003001);
        pin(1'b1, 8);
        cfg(24'h003000, 16'h3, 8'h87);
        pin(1'b0, 30);
        rdc(ADR_B_MAR, 32'hFF003003);
        rdc(ADR_B_CTRL, 32'h07);
        pin(1'b1, 8);
        cfg(24'h002000, 16'h0202, 8'h90);
        pulse(6'h01);
        rdc(ADR_B_CNT, 32'h0102);
        rdc(ADR_B_MAR, 32'hFF002001);
        pulse(6'h01);
        rdc(ADR_B_CNT, 32'h0202);
        rdc(ADR_B_CTRL, 32'h90);
        cfg(24'h002000, 16'h5, 8'h98);
        pulse(6'h01);
        rdc(ADR_B_MAR, 32'hFF002000);
        rdc(ADR_B_CNT, 32'h4);
        // Full address mode: fixed, +2, -1, and gated by channel A enable
        for (int i = 0; i < 4; i++) begin
            wr(ADR_A_SRC, 32'h004000);
            cfg(24'h005000, 16'h1, 8'h80);
            wr(ADR_A_CTRL, {24'h0, fa[i]});
            pulse(6'h01);
            rdc(ADR_A_SRC, {8'hFF, fs[i]});
            rdc(ADR_B_MAR, {8'hFF, fm[i]});
            if (i < 3) begin
                chk({31'h0, last.full}, 32'h1);
                chk({24'h0, last.io}, 32'h0);
                chk({8'h0, last.src}, 32'h004000);
                chk({8'h0, last.mem}, 32'h005000);
            end
            wr(ADR_A_CTRL, 32'h0);
        end
        // Queue fills to its depth while the drain side stalls
        xfer_ready <= 1'b0;
        cfg(24'h000000, 16'h0100, 8'h87);
        pin(1'b0, 40);
        chk({31'h0, xfer_valid}, 32'h1);
        rdc(ADR_B_CNT, 32'h0100 - FIFO_DEPTH);
        pin(1'b1, 8);
        n0 = nxf;
        xfer_ready <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(nxf - n0, FIFO_DEPTH);
        chk({31'h0, xfer_valid}, 32'h0);
        finish_test();
    end
endmodule : tb_dma_channel0_control_regs

`default_nettype wire
